// >>> core/sram_pkg.sv
// Shared constants for the synchronous SRAM core and its test port.
// Assumes a single 50 MHz system clock and an AXI4-Lite control bus.
package sram_pkg;
  // Data organisation
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int WORD_W = LANES * LANE_W;
  localparam int ADDR_W = 19;
  localparam int BEAT_W = 2;
  localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
  // Register map, byte addresses
  localparam logic [3:0] CTRL_OFFS = 4'h0;
  localparam logic [3:0] STATUS_OFFS = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int ST_SLEEP_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_WRITE_BIT = 2;
  localparam int ST_DRIVE_BIT = 3;
  localparam int ST_BURST_BIT = 4;
  localparam int ST_BEAT_LSB = 5;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Test access port
  localparam int IR_W = 2;
  localparam logic [IR_W-1:0] IR_IDCODE = 2'h1;
  localparam logic [IR_W-1:0] IR_BYPASS = 2'h3;
  localparam logic [IR_W-1:0] IR_CAPTURE = 2'h1;
  // Arbitrary identity value
  localparam logic [31:0] IDCODE_DEF = 32'h1234_5001;
endpackage : sram_pkg

// >>> core/sram_tap.sv
// Test access port controller with bypass and identity registers.
// Assumes test pins are synchronous to aclk and sampled there.
`timescale 1ns/1ns
module sram_tap #(
  parameter logic [31:0] IDCODE = sram_pkg::IDCODE_DEF
) (
  // System
  input wire logic aclk,
  input wire logic aresetn,
  // Test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo_o,
  output logic tdo_oe
);
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_st_t;

  tap_st_t st_r, st_nxt;
  logic tck_q_r;
  logic [sram_pkg::IR_W-1:0] ir_r, ir_sh_r;
  logic [31:0] dr_sh_r;
  logic rise, fall, tap_rst;

  assign rise = tck & ~tck_q_r;
  assign fall = ~tck & tck_q_r;
  // Power-up and test reset both force the idle reset state
  assign tap_rst = ~aresetn | ~trst_n;

  always_ff @(posedge aclk) begin
    if (!aresetn) tck_q_r <= 1'b1;
    else tck_q_r <= tck;
  end

  // Five high tms samples always reach TLR; an open tms pin reads high
  always_comb begin
    case (st_r)
      TLR: st_nxt = tms ? TLR : RTI;
      RTI: st_nxt = tms ? SEL_DR : RTI;
      SEL_DR: st_nxt = tms ? SEL_IR : CAP_DR;
      CAP_DR: st_nxt = tms ? EX1_DR : SH_DR;
      SH_DR: st_nxt = tms ? EX1_DR : SH_DR;
      EX1_DR: st_nxt = tms ? UPD_DR : PAU_DR;
      PAU_DR: st_nxt = tms ? EX2_DR : PAU_DR;
      EX2_DR: st_nxt = tms ? UPD_DR : SH_DR;
      UPD_DR: st_nxt = tms ? SEL_DR : RTI;
      SEL_IR: st_nxt = tms ? TLR : CAP_IR;
      CAP_IR: st_nxt = tms ? EX1_IR : SH_IR;
      SH_IR: st_nxt = tms ? EX1_IR : SH_IR;
      EX1_IR: st_nxt = tms ? UPD_IR : PAU_IR;
      PAU_IR: st_nxt = tms ? EX2_IR : PAU_IR;
      EX2_IR: st_nxt = tms ? UPD_IR : SH_IR;
      UPD_IR: st_nxt = tms ? SEL_DR : RTI;
      default: st_nxt = TLR;
    endcase
  end

  // Inputs are taken on the rising test-clock edge
  always_ff @(posedge aclk) begin
    if (tap_rst) begin
      st_r <= TLR;
      ir_r <= sram_pkg::IR_IDCODE;
      ir_sh_r <= sram_pkg::IR_CAPTURE;
      dr_sh_r <= 32'h0000_0000;
    end else if (rise) begin
      st_r <= st_nxt;
      case (st_r)
        TLR: ir_r <= sram_pkg::IR_IDCODE;
        CAP_IR: ir_sh_r <= sram_pkg::IR_CAPTURE;
        SH_IR: ir_sh_r <= {tdi, ir_sh_r[sram_pkg::IR_W-1:1]};
        UPD_IR: ir_r <= ir_sh_r;
        CAP_DR: dr_sh_r <= (ir_r == sram_pkg::IR_IDCODE) ? IDCODE
                                                        : 32'h0000_0000;
        SH_DR: begin
          if (ir_r == sram_pkg::IR_IDCODE) dr_sh_r <= {tdi, dr_sh_r[31:1]};
          else dr_sh_r <= {31'h0000_0000, tdi};
        end
        default: ir_r <= ir_r;
      endcase
    end
  end

  // Outputs change on the falling edge, driven only while shifting
  always_ff @(posedge aclk) begin
    if (tap_rst) begin
      tdo_o <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (fall) begin
      tdo_oe <= (st_r == SH_DR) || (st_r == SH_IR);
      tdo_o <= (st_r == SH_IR) ? ir_sh_r[0] : dr_sh_r[0];
    end
  end
endmodule : sram_tap

// >>> core/sram_core.sv
// Synchronous flow-through SRAM with burst counter, byte writes, sleep
// and test port, plus an AXI4-Lite control and status slave.
// Assumes all pins except out_enable_n are synchronous to aclk.
// Overview of operation
// - Each 9-bit byte lane has its own active-low write enable.
// - Byte enables are ignored on any edge where read/write reads high.
// - Enabled lanes reach the array one cycle after the write data.
// - Load with any chip enable false starts a deselect cycle.
// - Data bus floats one cycle after a deselect starts.
// - High chip enable acts like the low ones, polarity inverted.
// - Everything except output enable is timed by the rising clock edge.
// - Write data is captured in an input register on the rising edge.
// - Read data flows from the array to the pins without a register.
// - Burst order select high gives interleaved order, low gives linear.
// - Output enable high floats the data pins; reads show only when low.
// - Test inputs sampled on rising, outputs change on falling test clock.
// - Test inputs read high when left undriven.
// - Test data output drives only in shifting states.
// - Test port resets at power-up, on test reset and by tms sequence.
// - Sleep input high stops the internal clock.
// - Array contents are kept during sleep.
// - An undriven sleep input leaves the device awake.
// - Clock enable high makes an edge act as if it never happened.
// - Load takes new address; advance steps burst; deselected load ends it.
// - Access type comes from the load cycle; data moves one cycle later.
// - Address register loads only on a selected, enabled load edge.
`timescale 1ns/1ns
module sram_core #(
  parameter int ADDR_W = sram_pkg::ADDR_W,
  parameter logic [31:0] IDCODE = sram_pkg::IDCODE_DEF
) (
  // System
  input wire logic aclk,
  input wire logic aresetn,
  // Memory control
  input wire logic clock_gate_n,
  input wire logic advance_or_load,
  input wire logic chip_sel_low_a_n,
  input wire logic chip_sel_low_b_n,
  input wire logic chip_sel_high,
  input wire logic read_not_write,
  input wire logic [sram_pkg::LANES-1:0] byte_lane_write_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic out_enable_n,
  input wire logic burst_order_sel,
  input wire logic sleep_request,
  // Data bus
  input wire logic [31:0] data_lines_i,
  output logic [31:0] data_lines_o,
  output logic [31:0] data_lines_oe,
  input wire logic [3:0] parity_data_lines_i,
  output logic [3:0] parity_data_lines_o,
  output logic [3:0] parity_data_lines_oe,
  // Test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo_o,
  output logic tdo_oe,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int WW = sram_pkg::WORD_W;
  localparam int DEPTH = 1 << ADDR_W;

  // Byte enables to a lane-wide bit mask
  function automatic logic [WW-1:0] lane_mask(
    input logic [sram_pkg::LANES-1:0] be
  );
    logic [WW-1:0] m;
    m = '0;
    for (int i = 0; i < sram_pkg::LANES; i++) begin
      m[i*sram_pkg::LANE_W +: sram_pkg::LANE_W] = {sram_pkg::LANE_W{be[i]}};
    end
    return m;
  endfunction : lane_mask

  // Next low address bits of a four-beat burst
  function automatic logic [sram_pkg::BEAT_W-1:0] burst_low(
    input logic [sram_pkg::BEAT_W-1:0] start,
    input logic [sram_pkg::BEAT_W-1:0] beat,
    input logic interleave
  );
    if (interleave) return start ^ beat;
    else return start + beat;
  endfunction : burst_low

  logic [WW-1:0] mem [DEPTH];
  logic [31:0] ctrl_r;
  logic sleep_now, ce, selected, load;
  // Burst state
  logic burst_r, burst_wr_r;
  logic [ADDR_W-1:0] base_r;
  logic [sram_pkg::BEAT_W-1:0] beat_r, beat_nxt;
  // Data phase of the access taken last edge
  logic pend_r, pend_wr_r;
  logic [ADDR_W-1:0] pend_addr_r;
  logic [sram_pkg::LANES-1:0] pend_be_r;
  logic [sram_pkg::LANES-1:0] be_now;
  // Input register awaiting the array write
  logic cm_r;
  logic [ADDR_W-1:0] cm_addr_r;
  logic [sram_pkg::LANES-1:0] cm_be_r;
  logic [WW-1:0] din_r, bus_word, rd_word;
  logic drive;

  // Sleep stops the internal clock; pin pull-down handled in the pad
  assign sleep_now = sleep_request | ctrl_r[sram_pkg::CTRL_SLEEP_BIT];
  assign ce = ~clock_gate_n & ~sleep_now;
  assign selected = ~chip_sel_low_a_n & ~chip_sel_low_b_n
                    & chip_sel_high;
  assign load = ~advance_or_load;
  // Read/write high masks every byte enable
  assign be_now = read_not_write ? '0 : ~byte_lane_write_n;
  assign beat_nxt = beat_r + 2'h1;

  // Lane i of the word is {parity bit i, data byte i}
  genvar g;
  generate
    for (g = 0; g < sram_pkg::LANES; g++) begin : g_lane
      assign bus_word[g*sram_pkg::LANE_W +: sram_pkg::LANE_W] =
        {parity_data_lines_i[g], data_lines_i[g*8 +: 8]};
      assign data_lines_o[g*8 +: 8] =
        rd_word[g*sram_pkg::LANE_W +: 8];
      assign parity_data_lines_o[g] =
        rd_word[g*sram_pkg::LANE_W + 8];
    end
  endgenerate

  // Command stage: load, advance or deselect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_r <= 1'b0;
      burst_wr_r <= 1'b0;
      base_r <= '0;
      beat_r <= sram_pkg::BEAT_RST;
      pend_r <= 1'b0;
      pend_wr_r <= 1'b0;
      pend_addr_r <= '0;
      pend_be_r <= '0;
    end else if (ce) begin
      if (load && selected) begin
        burst_r <= 1'b1;
        burst_wr_r <= ~read_not_write;
        base_r <= address;
        beat_r <= sram_pkg::BEAT_RST;
        pend_r <= 1'b1;
        pend_wr_r <= ~read_not_write;
        pend_addr_r <= address;
        pend_be_r <= be_now;
      end else if (load) begin
        burst_r <= 1'b0;
        pend_r <= 1'b0;
        pend_be_r <= '0;
      end else if (burst_r) begin
        beat_r <= beat_nxt;
        pend_r <= 1'b1;
        pend_wr_r <= burst_wr_r;
        pend_addr_r <= {base_r[ADDR_W-1:sram_pkg::BEAT_W],
          burst_low(base_r[sram_pkg::BEAT_W-1:0], beat_nxt,
                    burst_order_sel)};
        pend_be_r <= be_now;
      end else begin
        pend_r <= 1'b0;
        pend_be_r <= '0;
      end
    end
  end

  // Data stage: write data into the input register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cm_r <= 1'b0;
      cm_addr_r <= '0;
      cm_be_r <= '0;
      din_r <= '0;
    end else if (ce) begin
      cm_r <= pend_r & pend_wr_r;
      if (pend_r && pend_wr_r) begin
        din_r <= bus_word;
        cm_addr_r <= pend_addr_r;
        cm_be_r <= pend_be_r;
      end
    end
  end

  // Array write of enabled lanes one cycle later; nothing moves asleep
  always_ff @(posedge aclk) begin
    if (ce && cm_r) begin
      mem[cm_addr_r] <= (mem[cm_addr_r] & ~lane_mask(cm_be_r))
                        | (din_r & lane_mask(cm_be_r));
    end
  end

  // Flow-through read, forwarding a write still in the input register
  always_comb begin
    rd_word = mem[pend_addr_r];
    if (cm_r && cm_addr_r == pend_addr_r) begin
      rd_word = (rd_word & ~lane_mask(cm_be_r))
                | (din_r & lane_mask(cm_be_r));
    end
  end

  // Drive only for a read data phase and with output enable low
  assign drive = pend_r & ~pend_wr_r & ~out_enable_n;
  assign data_lines_oe = {32{drive}};
  assign parity_data_lines_oe = {4{drive}};

  sram_tap #(
    .IDCODE(IDCODE)
  ) u_tap (
    .aclk(aclk),
    .aresetn(aresetn),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .trst_n(trst_n),
    .tdo_o(tdo_o),
    .tdo_oe(tdo_oe)
  );

  // AXI4-Lite slave
  logic aw_hold_r, w_hold_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] status;
  logic [31:0] ctrl_wmask;

  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  generate
    for (g = 0; g < 4; g++) begin : g_strb
      assign ctrl_wmask[g*8 +: 8] = {8{wstrb_r[g]}};
    end
  endgenerate

  always_comb begin
    status = '0;
    status[sram_pkg::ST_SLEEP_BIT] = sleep_now;
    status[sram_pkg::ST_PEND_BIT] = pend_r;
    status[sram_pkg::ST_WRITE_BIT] = cm_r;
    status[sram_pkg::ST_DRIVE_BIT] = drive;
    status[sram_pkg::ST_BURST_BIT] = burst_r;
    status[sram_pkg::ST_BEAT_LSB +: sram_pkg::BEAT_W] = beat_r;
  end

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= s_axi_awaddr[3:0];
    end else if (aw_hold_r && w_hold_r) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (aw_hold_r && w_hold_r) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= sram_pkg::CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sram_pkg::RESP_OKAY;
    end else if (aw_hold_r && w_hold_r) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_r == sram_pkg::CTRL_OFFS) begin
        ctrl_r <= (ctrl_r & ~ctrl_wmask) | (wdata_r & ctrl_wmask);
        s_axi_bresp <= sram_pkg::RESP_OKAY;
      end else if (awaddr_r == sram_pkg::STATUS_OFFS) begin
        s_axi_bresp <= sram_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= sram_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sram_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sram_pkg::RESP_OKAY;
      case (s_axi_araddr[3:0])
        sram_pkg::CTRL_OFFS: s_axi_rdata <= ctrl_r;
        sram_pkg::STATUS_OFFS: s_axi_rdata <= status;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= sram_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : sram_core

// >>> verif/sram_core_sva.sv
// Checker for memory pin timing, test port and control bus handshakes.
// Assumes it is bound into sram_core and sees only its ports.
`timescale 1ns/1ns
module sram_core_sva (
  // System
  input wire logic aclk,
  input wire logic aresetn,
  // Memory pins
  input wire logic clock_gate_n,
  input wire logic advance_or_load,
  input wire logic chip_sel_low_a_n,
  input wire logic chip_sel_low_b_n,
  input wire logic chip_sel_high,
  input wire logic read_not_write,
  input wire logic out_enable_n,
  input wire logic sleep_request,
  input wire logic [31:0] data_lines_o,
  input wire logic [31:0] data_lines_oe,
  input wire logic [3:0] parity_data_lines_oe,
  // Test port
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo_oe,
  // Control bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  logic sel, ld;
  assign sel = !chip_sel_low_a_n && !chip_sel_low_b_n && chip_sel_high;
  assign ld = !clock_gate_n && !sleep_request && !advance_or_load;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_read_drive: assert property (
    ld && sel && read_not_write ##1 !out_enable_n |-> &data_lines_oe)
    else $error("read data not driven");
  a_desel_float: assert property (
    ld && !sel |=> data_lines_oe == '0 && parity_data_lines_oe == '0)
    else $error("bus driven after deselect");
  a_write_float: assert property (
    ld && sel && !read_not_write |=> data_lines_oe == '0)
    else $error("bus driven in write data cycle");
  a_oe_async: assert property (
    out_enable_n |-> data_lines_oe == '0 && parity_data_lines_oe == '0)
    else $error("bus driven with output enable off");
  a_gate_hold: assert property (
    clock_gate_n ##1 $stable(out_enable_n)
    |-> $stable(data_lines_oe) && $stable(data_lines_o))
    else $error("outputs moved on gated edge");
  a_read_turn: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_tdo_on_fall: assert property (
    $rose(tdo_oe) |-> !$past(tck) && $past(tck, 2))
    else $error("test output moved off a falling test clock");
  a_test_reset: assert property (
    !trst_n |-> ##[1:2] !tdo_oe)
    else $error("test output driven after test reset");
  cover property (ld && sel && read_not_write);
  cover property (ld && !sel);
  cover property ($rose(tdo_oe));
endmodule : sram_core_sva
bind sram_core sram_core_sva u_sva (.*);

// >>> verif/sram_ctl_model.sv
// Memory controller model driving the SRAM pins one command a cycle.
// Assumes one shared clock; write data follows its command by a cycle.
`timescale 1ns/1ns
module sram_ctl_model (
  // Clock
  input wire logic aclk,
  // Commands
  output logic clock_gate_n,
  output logic advance_or_load,
  output logic chip_sel_low_a_n,
  output logic chip_sel_low_b_n,
  output logic chip_sel_high,
  output logic read_not_write,
  output logic [3:0] byte_lane_write_n,
  output logic [3:0] address,
  output logic out_enable_n,
  output logic sleep_request,
  // Data bus
  input wire logic [31:0] data_lines_o,
  input wire logic [31:0] data_lines_oe,
  input wire logic [3:0] parity_data_lines_o,
  input wire logic [3:0] parity_data_lines_oe,
  output logic [31:0] data_lines_i,
  output logic [3:0] parity_data_lines_i
);
  logic drv, pw, zz, oen;
  logic [35:0] wd, pd, noise, bus, oe, seen;
  assign oe = {parity_data_lines_oe, data_lines_oe};
  assign bus = (oe & {parity_data_lines_o, data_lines_o})
    | (~oe & (drv ? wd : noise));
  assign {parity_data_lines_i, data_lines_i} = bus;
  // A floating bus changes every cycle so stale data never passes
  always @(posedge aclk) noise <= noise + 36'h1_2345_6789;
  // Clock enabled from the start: no gated edge ahead of the first write
  initial begin
    {clock_gate_n, advance_or_load, read_not_write} = 3'h3;
    {chip_sel_low_a_n, chip_sel_low_b_n, chip_sel_high} = 3'h6;
    byte_lane_write_n = 4'hF;
    address = 4'h0;
    {out_enable_n, sleep_request, drv, pw, zz, oen} = 6'h0;
    {wd, pd, noise} = '0;
  end
  task step(input logic g, ld, input logic [2:0] cs, input logic rnw,
            input logic [3:0] be, a, input logic [35:0] d);
    @(posedge aclk);
    clock_gate_n <= g;
    advance_or_load <= !ld;
    {chip_sel_low_a_n, chip_sel_low_b_n, chip_sel_high} <= cs;
    read_not_write <= rnw;
    byte_lane_write_n <= be;
    address <= a;
    sleep_request <= zz;
    out_enable_n <= oen;
    if (!g) begin
      drv <= pw;
      wd <= pd;
      pw = !rnw && (!ld || cs == 3'h1);
      pd = d;
    end
    @(negedge aclk);
    seen = bus;
  endtask : step
endmodule : sram_ctl_model

// >>> verif/sram_core_tb_top.sv
// Self-checking bench for sram_core: memory pins, test port, control bus.
// Assumes the controller model sram_ctl_model and the bound checker.
`timescale 1ns/1ns
module sram_core_tb_top;
  localparam logic [31:0] IDC = 32'h0ABC_D001; // Arbitrary value
  localparam logic [2:0] SEL = 3'h1;
  logic aclk, aresetn, clock_gate_n, advance_or_load, chip_sel_low_a_n;
  logic chip_sel_low_b_n, chip_sel_high, read_not_write, out_enable_n;
  logic burst_order_sel, sleep_request, tck, tms, tdi, trst_n, tdo_o;
  logic tdo_oe, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [3:0] byte_lane_write_n, address, parity_data_lines_i, s_axi_wstrb;
  logic [3:0] parity_data_lines_o, parity_data_lines_oe;
  logic [31:0] data_lines_i, data_lines_o, data_lines_oe;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [35:0] mem [16];
  int err_count, checks_done, cyc;
  sram_core #(.ADDR_W(4), .IDCODE(IDC)) u_dut (.*);
  sram_ctl_model u_ctl (.*);
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  task chk(input string n, input logic [35:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  function logic [35:0] lanes(input logic [3:0] be_n);
    lanes = '0;
    for (int i = 0; i < 4; i++) begin
      if (!be_n[i]) lanes = lanes | (36'hFF << 8 * i) | (36'h1 << 32 + i);
    end
  endfunction : lanes
  function logic [35:0] pat(input logic [3:0] a);
    pat = {a, {8{a}}};
  endfunction : pat
  task wr(input logic [3:0] a, be, input logic [35:0] d);
    u_ctl.step(1'h0, 1'h1, SEL, 1'h0, be, a, d);
  endtask : wr
  task rd(input logic [3:0] a);
    u_ctl.step(1'h0, 1'h1, SEL, 1'h1, 4'h0, a, '0);
  endtask : rd
  task adv;
    u_ctl.step(1'h0, 1'h0, SEL, 1'h1, 4'h0, 4'hE, '0);
  endtask : adv
  task idle;
    u_ctl.step(1'h0, 1'h1, 3'h6, 1'h1, 4'hF, 4'h0, '0);
  endtask : idle
  task rd_chk(input string n, input logic [35:0] e);
    chk(n, e, u_ctl.seen);
    chk("drive", 36'h1, {35'h0, &{data_lines_oe, parity_data_lines_oe}});
  endtask : rd_chk
  task rst(input logic bo);
    @(posedge aclk);
    aresetn <= 1'h0;
    burst_order_sel <= bo;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
  endtask : rst
  task t_wr_rd;
    for (int i = 0; i < 8; i++) begin
      wr(4'(i), 4'h0, pat(4'(i)));
      mem[i] = pat(4'(i));
    end
    wr(4'h1, 4'hA, '1);
    mem[1] = mem[1] | lanes(4'hA);
    rd(4'h1);
    rd(4'h0);
    rd_chk("word1", mem[1]);
    rd(4'h1);
    rd_chk("word0", mem[0]);
    idle;
    rd_chk("word1_again", mem[1]);
  endtask : t_wr_rd
  task t_desel;
    for (int j = 0; j < 3; j++) begin
      rd(4'h2);
      u_ctl.step(1'h0, 1'h1, SEL ^ (3'h4 >> j), 1'h1, 4'h0, 4'h3, '0);
      rd_chk("pre_desel", mem[2]);
      adv;
      chk("desel_oe", '0, {4'h0, data_lines_oe});
      idle;
      chk("adv_oe", '0, {4'h0, data_lines_oe});
    end
  endtask : t_desel
  task t_gate;
    rd(4'h3);
    u_ctl.step(1'h1, 1'h1, SEL, 1'h0, 4'h0, 4'h3, '0);
    rd_chk("gate_a", mem[3]);
    idle;
    rd_chk("gate_b", mem[3]);
    u_ctl.zz = 1'h1;
    wr(4'h3, 4'h0, '0);
    idle;
    u_ctl.zz = 1'h0;
    rd(4'h3);
    idle;
    rd_chk("sleep", mem[3]);
  endtask : t_gate
  task t_oe;
    u_ctl.oen = 1'h1;
    rd(4'h0);
    idle;
    chk("oe_off", '0, {4'h0, data_lines_oe});
    u_ctl.oen = 1'h0;
  endtask : t_oe
  task t_burst(input logic il);
    logic [3:0] a;
    rst(il);
    rd(4'h5);
    for (int k = 0; k < 4; k++) begin
      a = il ? {2'h1, 2'h1 ^ 2'(k)} : {2'h1, 2'(k + 1)};
      if (k < 3)
        adv;
      else
        idle;
      rd_chk("beat", mem[a]);
    end
  endtask : t_burst
  task axw(input logic [31:0] a, d, input logic [3:0] s,
           input logic [1:0] er);
    logic b;
    b = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        b = 1'h1;
        s_axi_bready <= 1'h0;
        chk("bresp", {34'h0, er}, {34'h0, s_axi_bresp});
      end
    end
  endtask : axw
  task axr(input logic [31:0] a, e, input logic [1:0] er);
    logic b;
    b = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        b = 1'h1;
        s_axi_rready <= 1'h0;
        chk("rdata", {4'h0, e}, {4'h0, s_axi_rdata});
        chk("rresp", {34'h0, er}, {34'h0, s_axi_rresp});
      end
    end
  endtask : axr
  task t_axi;
    logic [31:0] c, st, bt;
    c = 32'(sram_pkg::CTRL_OFFS);
    st = 32'(sram_pkg::STATUS_OFFS);
    // Beat count stays at 3 after the last four-beat burst
    bt = 32'h3 << sram_pkg::ST_BEAT_LSB;
    axr(c, sram_pkg::CTRL_RST, sram_pkg::RESP_OKAY);
    axw(c, 32'h1, 4'hE, sram_pkg::RESP_OKAY);
    axr(st, bt, sram_pkg::RESP_OKAY);
    axw(c, 32'h1, 4'hF, sram_pkg::RESP_OKAY);
    axw(st, '1, 4'hF, sram_pkg::RESP_OKAY);
    axr(st, bt | 32'h1, sram_pkg::RESP_OKAY);
    axw(32'h8, 32'h1, 4'hF, sram_pkg::RESP_SLVERR);
    axr(32'h8, 32'h0, sram_pkg::RESP_SLVERR);
    axw(c, 32'h0, 4'hF, sram_pkg::RESP_OKAY);
    axr(st, bt, sram_pkg::RESP_OKAY);
  endtask : t_axi
  task tclk(input logic m);
    @(posedge aclk);
    tms <= m;
    tck <= 1'h1;
    repeat (2) @(posedge aclk);
    tck <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask : tclk
  task t_tap;
    logic [31:0] got;
    @(posedge aclk);
    trst_n <= 1'h0;
    repeat (2) @(posedge aclk);
    trst_n <= 1'h1;
    chk("tdo_oe_rst", '0, {35'h0, tdo_oe});
    for (int i = 0; i < 9; i++) tclk(i < 5 || i == 6);
    chk("tdo_oe_shift", 36'h1, {35'h0, tdo_oe});
    for (int i = 0; i < 32; i++) begin
      got[i] = tdo_o;
      tclk(i == 31);
    end
    chk("idcode", {4'h0, IDC}, {4'h0, got});
    chk("tdo_oe_exit", '0, {35'h0, tdo_oe});
  endtask : t_tap
  initial begin
    {aresetn, burst_order_sel, tck, tdi} = 4'h0;
    {tms, trst_n} = 2'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    rst(1'h0);
    t_wr_rd;
    t_desel;
    t_gate;
    t_oe;
    t_burst(1'h0);
    t_burst(1'h1);
    t_axi;
    t_tap;
    conclude;
  end
endmodule : sram_core_tb_top
